// *** verilog/cbbi_map.svh ***
// Constants of the backplane interface: offsets, fields, resets, timing
`ifndef CBBI_MAP_SVH
`define CBBI_MAP_SVH
// Register indices on the plain register port
`define CBBI_REG_CTRL 4'h0
`define CBBI_REG_MMU_CBAR 4'h1
`define CBBI_REG_MMU_CBR 4'h2
`define CBBI_REG_MMU_BBR 4'h3
`define CBBI_REG_SOCK0 4'h4
`define CBBI_REG_SOCK1 4'h5
`define CBBI_REG_IOBASE 4'h6
`define CBBI_REG_STATUS 4'h7
`define CBBI_REG_KICK 4'h8
// Control register fields
`define CBBI_CTRL_MWAIT_LSB 0
`define CBBI_CTRL_IOWAIT_LSB 2
`define CBBI_CTRL_REFEN_BIT 5
`define CBBI_CTRL_TOGEN_BIT 6
`define CBBI_CTRL_RESET 8'h20
// Socket register fields: base in 8K units, size code
`define CBBI_SOCK_BASE_LSB 0
`define CBBI_SOCK_SIZE_LSB 3
`define CBBI_SOCK_EN_BIT 5
`define CBBI_SOCK0_RESET 8'h20
`define CBBI_SOCK1_RESET 8'h00
`define CBBI_MMU_CBAR_RESET 8'hf0
`define CBBI_IOBASE_RESET 8'h00
// Memory and I/O wait limits
`define CBBI_MWAIT_MAX 3'h3
`define CBBI_IOWAIT_MAX 3'h6
// Watchdog interval
`define CBBI_WDOG_MS 1000
`define CBBI_CLK_KHZ 50000
`endif

// *** verilog/cbbi_pkg.sv ***
// Types of the backplane interface
package cbbi_pkg;
  typedef enum logic [2:0] {
    CBBI_IDLE,
    CBBI_ADDR,
    CBBI_SYNC,
    CBBI_WAIT,
    CBBI_DATA
  } cbbi_state_t;
  typedef enum logic [1:0] {
    CBBI_SZ_8K,
    CBBI_SZ_16K,
    CBBI_SZ_32K,
    CBBI_SZ_RSV
  } cbbi_size_t;
endpackage

// *** verilog/cbbi_sock_dec.sv ***
// Decoder of one on-board memory socket within the low 64K
`timescale 1ns/10ps
`include "cbbi_map.svh"
module cbbi_sock_dec
  import cbbi_pkg::*;
(
  // Socket setup
  input wire logic [7:0] cfg_i,
  // Physical address
  input wire logic [19:0] addr_i,
  // Select
  output logic hit_o
);
  logic [2:0] base;
  logic [1:0] size;
  logic [2:0] mask;
  assign base = cfg_i[`CBBI_SOCK_BASE_LSB +: 3];
  assign size = cfg_i[`CBBI_SOCK_SIZE_LSB +: 2];
  always_comb begin
    unique case (cbbi_size_t'(size))
      CBBI_SZ_8K: mask = 3'h7;
      CBBI_SZ_16K: mask = 3'h6;
      CBBI_SZ_32K: mask = 3'h4;
      default: mask = 3'h7;
    endcase
  end
  // Any 8K boundary for 8K size, size-aligned for 16K and 32K, lowest 64K only
  assign hit_o = cfg_i[`CBBI_SOCK_EN_BIT] && addr_i[19:16] == 4'h0 &&
                 ((addr_i[15:13] & mask) == (base & mask));
endmodule // cbbi_sock_dec

// *** verilog/cbbi_top.sv ***
// Backplane interface of the single-board computer
`timescale 1ns/10ps
`include "cbbi_map.svh"

// Notes on behaviour
// - Form 20-bit address each memory cycle
// - Upper four bits on data lines 0-3
// - Top address bit always low
// - Map 64K logical into 512K physical
// - Two sockets, size-aligned boundaries, low 64K
// - Data buffers steered both directions
// - Zero to three memory wait states
// - Zero to six I/O wait states
// - Full 16-bit I/O address
// - Internal register block 64-byte relocatable
// - Refresh strobe gated unless disabled
// - Memory expansion select grounded
// - I/O expansion select grounded
// - Timer output takes address bit 18
// - Block memory write on supply fault
// - Jumpered watchdog resets after one second
// - Standard cycle timing
module cbbi_top
  import cbbi_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES =
    `CBBI_WDOG_MS * `CBBI_CLK_KHZ
)(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Processor cycle request
  input wire logic cyc_req_i,
  input wire logic cyc_io_i,
  input wire logic cyc_write_i,
  input wire logic cyc_dma_i,
  input wire logic cyc_fetch_i,
  input wire logic [15:0] cyc_addr_i,
  input wire logic [7:0] cyc_wdata_i,
  output logic cyc_done_o,
  output logic [7:0] cyc_rdata_o,
  output logic cyc_internal_o,
  // Pins from outside the clock domain
  input wire logic supply_fault_i,
  input wire logic wdog_jumper_i,
  input wire logic wdog_kick_i,
  input wire logic timer_toggle_output_i,
  // Backplane bus
  output logic [15:0] bus_addr_o,
  input wire logic [7:0] bus_data_i,
  output logic [7:0] bus_data_o,
  output logic bus_data_oe_o,
  output logic bus_mem_rq_n_o,
  output logic bus_io_rq_n_o,
  output logic bus_rd_n_o,
  output logic bus_wr_n_o,
  output logic bus_mcsync_n_o,
  output logic bus_refresh_n_o,
  output logic bus_memex_o,
  output logic bus_ioexp_o,
  output logic timer_pin_o,
  // On-board sockets, buffers and processor reset
  output logic [1:0] sock_sel_o,
  output logic buf_to_bus_o,
  output logic cpu_reset_o
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic kick_prev;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else if (clk_en_i) begin
      pin_s1 <= {timer_toggle_output_i, wdog_kick_i, wdog_jumper_i,
                 supply_fault_i};
      pin_s2 <= pin_s1;
    end
  end
  logic fault_s;
  logic jumper_s;
  logic kick_s;
  logic toggle_s;
  assign fault_s = pin_s2[0];
  assign jumper_s = pin_s2[1];
  assign kick_s = pin_s2[2];
  assign toggle_s = pin_s2[3];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] ctrl;
  logic [7:0] cbar;
  logic [7:0] cbr;
  logic [7:0] bbr;
  logic [7:0] sock0;
  logic [7:0] sock1;
  logic [7:0] iobase;
  logic sw_kick;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= `CBBI_CTRL_RESET;
      cbar <= `CBBI_MMU_CBAR_RESET;
      cbr <= 8'h00;
      bbr <= 8'h00;
      sock0 <= `CBBI_SOCK0_RESET;
      sock1 <= `CBBI_SOCK1_RESET;
      iobase <= `CBBI_IOBASE_RESET;
      sw_kick <= 1'b0;
    end else if (clk_en_i) begin
      sw_kick <= reg_wr_i && reg_addr_i == `CBBI_REG_KICK;
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          `CBBI_REG_CTRL: ctrl <= reg_wdata_i;
          `CBBI_REG_MMU_CBAR: cbar <= reg_wdata_i;
          `CBBI_REG_MMU_CBR: cbr <= reg_wdata_i;
          `CBBI_REG_MMU_BBR: bbr <= reg_wdata_i;
          `CBBI_REG_SOCK0: sock0 <= reg_wdata_i;
          `CBBI_REG_SOCK1: sock1 <= reg_wdata_i;
          `CBBI_REG_IOBASE: iobase <= reg_wdata_i;
          default: ;
        endcase
      end
    end
  end
  logic [1:0] mwait_cfg;
  logic [2:0] iowait_cfg;
  assign mwait_cfg = ctrl[`CBBI_CTRL_MWAIT_LSB +: 2];
  // Codes above six clamp, so software cannot exceed the I/O limit
  assign iowait_cfg = (ctrl[`CBBI_CTRL_IOWAIT_LSB +: 3] > `CBBI_IOWAIT_MAX)
    ? `CBBI_IOWAIT_MAX : ctrl[`CBBI_CTRL_IOWAIT_LSB +: 3];
  logic tog_en;
  assign tog_en = ctrl[`CBBI_CTRL_TOGEN_BIT];

  logic [7:0] status;
  logic wdog_fired;
  assign status = {4'h0, wdog_fired, jumper_s, toggle_s, fault_s};
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          `CBBI_REG_CTRL: reg_rdata_o <= ctrl;
          `CBBI_REG_MMU_CBAR: reg_rdata_o <= cbar;
          `CBBI_REG_MMU_CBR: reg_rdata_o <= cbr;
          `CBBI_REG_MMU_BBR: reg_rdata_o <= bbr;
          `CBBI_REG_SOCK0: reg_rdata_o <= sock0;
          `CBBI_REG_SOCK1: reg_rdata_o <= sock1;
          `CBBI_REG_IOBASE: reg_rdata_o <= iobase;
          `CBBI_REG_STATUS: reg_rdata_o <= status;
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // Address translation
  // ****************************************************************
  // Common area 0 below bank base, bank area, then common area 1
  logic [3:0] la_page;
  logic [7:0] base_sel;
  logic [19:0] phys;
  assign la_page = cyc_addr_i[15:12];
  always_comb begin
    if (la_page >= cbar[7:4]) begin
      base_sel = cbr;
    end else if (la_page >= cbar[3:0]) begin
      base_sel = bbr;
    end else begin
      base_sel = 8'h00;
    end
  end
  assign phys = {base_sel + {4'h0, la_page}, cyc_addr_i[11:0]};

  logic [1:0] hit;
  cbbi_sock_dec u_sock0 (
    .cfg_i(sock0),
    .addr_i(phys),
    .hit_o(hit[0])
  );
  cbbi_sock_dec u_sock1 (
    .cfg_i(sock1),
    .addr_i(phys),
    .hit_o(hit[1])
  );

  logic io_int;
  assign io_int = cyc_io_i && cyc_addr_i[15:6] == {2'b00, iobase};

  // ****************************************************************
  // Bus cycle sequencer
  // ****************************************************************
  cbbi_state_t state;
  logic [2:0] wcnt;
  logic c_io;
  logic c_wr;
  logic c_fetch;
  logic [19:0] c_phys;
  logic [7:0] c_wdata;
  logic [1:0] c_hit;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= CBBI_IDLE;
      wcnt <= 3'h0;
      c_io <= 1'b0;
      c_wr <= 1'b0;
      c_fetch <= 1'b0;
      c_phys <= 20'h00000;
      c_wdata <= 8'h00;
      c_hit <= 2'b00;
    end else if (clk_en_i) begin
      unique case (state)
        CBBI_IDLE: begin
          if (cyc_req_i && !io_int) begin
            state <= CBBI_ADDR;
            c_io <= cyc_io_i;
            c_wr <= cyc_write_i;
            c_fetch <= cyc_fetch_i && !cyc_dma_i;
            c_wdata <= cyc_wdata_i;
            c_hit <= cyc_io_i ? 2'b00 : hit;
            c_phys <= cyc_io_i ? {4'h0, cyc_addr_i} : phys;
          end
        end
        CBBI_ADDR: state <= CBBI_SYNC;
        CBBI_SYNC: begin
          // Wait count covers both processor and DMA memory cycles
          wcnt <= c_io ? iowait_cfg : {1'b0, mwait_cfg};
          state <= CBBI_WAIT;
        end
        CBBI_WAIT: begin
          if (wcnt == 3'h0) begin
            state <= CBBI_DATA;
          end else begin
            wcnt <= wcnt - 3'h1;
          end
        end
        CBBI_DATA: state <= CBBI_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Backplane drive
  // ****************************************************************
  logic [19:0] phys_out;
  // Bit 18 lost to the timer pin, bit 19 never driven high
  assign phys_out = {1'b0, c_phys[18] & ~tog_en, c_phys[17:0]};
  logic active;
  assign active = state != CBBI_IDLE;
  logic wr_ok;
  assign wr_ok = c_wr && !(fault_s && !c_io);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_addr_o <= 16'h0000;
      bus_data_o <= 8'h00;
      bus_data_oe_o <= 1'b0;
      bus_mem_rq_n_o <= 1'b1;
      bus_io_rq_n_o <= 1'b1;
      bus_rd_n_o <= 1'b1;
      bus_wr_n_o <= 1'b1;
      bus_mcsync_n_o <= 1'b1;
      bus_refresh_n_o <= 1'b1;
      sock_sel_o <= 2'b00;
      buf_to_bus_o <= 1'b0;
      cyc_done_o <= 1'b0;
      cyc_rdata_o <= 8'h00;
      cyc_internal_o <= 1'b0;
      timer_pin_o <= 1'b0;
    end else if (clk_en_i) begin
      cyc_done_o <= state == CBBI_DATA;
      cyc_internal_o <= state == CBBI_IDLE && cyc_req_i && io_int;
      bus_addr_o <= active ? phys_out[15:0] : 16'h0000;
      bus_mem_rq_n_o <= !(active && !c_io);
      bus_io_rq_n_o <= !(active && c_io);
      // Strobes only after the address phase, per standard timing
      bus_mcsync_n_o <= !(state == CBBI_SYNC || state == CBBI_WAIT);
      bus_rd_n_o <= !((state == CBBI_SYNC || state == CBBI_WAIT) && !c_wr);
      bus_wr_n_o <= !((state == CBBI_SYNC || state == CBBI_WAIT) && wr_ok);
      if (state == CBBI_ADDR && !c_io) begin
        bus_data_o <= {4'h0, phys_out[19:16]};
        bus_data_oe_o <= 1'b1;
      end else if ((state == CBBI_SYNC || state == CBBI_WAIT) && wr_ok) begin
        bus_data_o <= c_wdata;
        bus_data_oe_o <= 1'b1;
      end else begin
        bus_data_o <= 8'h00;
        bus_data_oe_o <= 1'b0;
      end
      // Refresh on fetches only, so it stays out of data cycles
      bus_refresh_n_o <= !(state == CBBI_SYNC && c_fetch &&
                           ctrl[`CBBI_CTRL_REFEN_BIT]);
      sock_sel_o <= active ? c_hit : 2'b00;
      // Socket read drives the bus side, so DMA can read too
      buf_to_bus_o <= active && (c_hit != 2'b00) && !c_wr;
      if (state == CBBI_WAIT && wcnt == 3'h0 && !c_wr) begin
        cyc_rdata_o <= bus_data_i;
      end
      timer_pin_o <= tog_en ? toggle_s : 1'b0;
    end
  end

  // ****************************************************************
  // Grounded expansion lines
  // ****************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_memex_o <= 1'b0;
      bus_ioexp_o <= 1'b0;
    end else begin
      bus_memex_o <= 1'b0;
      bus_ioexp_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  logic [31:0] wd_cnt;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_cnt <= 32'h0;
      kick_prev <= 1'b0;
      wdog_fired <= 1'b0;
      cpu_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      kick_prev <= kick_s;
      cpu_reset_o <= 1'b0;
      if (!jumper_s || (kick_s && !kick_prev) || sw_kick) begin
        wd_cnt <= 32'h0;
      end else if (wd_cnt >= WDOG_CYCLES - 1) begin
        wd_cnt <= 32'h0;
        cpu_reset_o <= 1'b1;
        wdog_fired <= 1'b1;
      end else begin
        wd_cnt <= wd_cnt + 32'h1;
      end
    end
  end
endmodule // cbbi_top

// *** testbench/cbbi_card.sv ***
// Behavioural memory and I/O card on the far side of the backplane
`timescale 1ns/10ps
module cbbi_card (
  // Backplane as seen by the card
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wire_i,
  input wire logic mem_n_i,
  input wire logic io_n_i,
  input wire logic rd_n_i,
  input wire logic sync_n_i,
  // Card drive onto the data lines
  output logic [7:0] data_o
);
  logic [3:0] up = 4'h0;
  logic [7:0] junk = 8'h00;
  // Upper bits held from the address phase for the whole cycle
  always @(posedge clk_i) begin
    if (!mem_n_i && sync_n_i) up <= wire_i[3:0];
    junk <= ~junk;
  end
  // Released lines keep changing so stale data never looks valid
  assign data_o = rd_n_i ? junk : !mem_n_i ? {up, addr_i[3:0]} :
    !io_n_i ? addr_i[7:0] : junk;
endmodule // cbbi_card

// *** testbench/cbbi_top_asserts.sv ***
// Port checks of the backplane interface
`timescale 1ns/10ps
module cbbi_top_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic supply_fault_i,
  input wire logic wdog_jumper_i,
  input wire logic timer_toggle_output_i,
  input wire logic cyc_done_o,
  input wire logic [7:0] bus_data_o,
  input wire logic bus_data_oe_o,
  input wire logic bus_mem_rq_n_o,
  input wire logic bus_io_rq_n_o,
  input wire logic bus_rd_n_o,
  input wire logic bus_wr_n_o,
  input wire logic bus_mcsync_n_o,
  input wire logic bus_refresh_n_o,
  input wire logic bus_memex_o,
  input wire logic bus_ioexp_o,
  input wire logic timer_pin_o,
  input wire logic cpu_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_addr; $fell(bus_mem_rq_n_o); endsequence
  sequence s_sync_rd; $fell(bus_mcsync_n_o) && !bus_rd_n_o; endsequence
  property p_memex; !bus_memex_o; endproperty
  property p_ioexp; !bus_ioexp_o; endproperty
  property p_upper; s_addr |-> bus_data_oe_o && bus_data_o[7:3] == 5'h00;
  endproperty
  property p_mwait; s_addr |-> ##[3:6] cyc_done_o; endproperty
  property p_iowait;
    $fell(bus_io_rq_n_o) |-> bus_mem_rq_n_o ##[3:9] cyc_done_o;
  endproperty
  property p_release; s_sync_rd |-> !bus_data_oe_o; endproperty
  property p_refresh;
    !bus_refresh_n_o |-> !bus_mcsync_n_o ##1 bus_refresh_n_o;
  endproperty
  // Synchroniser needs the pin stable for a few edges
  property p_fault;
    supply_fault_i[*4] |-> bus_wr_n_o || !bus_io_rq_n_o;
  endproperty
  property p_timer; !timer_toggle_output_i[*4] |-> !timer_pin_o; endproperty
  property p_wdog; !wdog_jumper_i[*4] |-> !cpu_reset_o; endproperty
  property p_done; cyc_done_o |=> !cyc_done_o; endproperty
  a_memex: assert property (p_memex)
    else $error("memory expansion select driven");
  a_ioexp: assert property (p_ioexp)
    else $error("io expansion select driven");
  a_upper: assert property (p_upper)
    else $error("upper address on data lines wrong");
  a_mwait: assert property (p_mwait)
    else $error("memory cycle length out of range");
  a_iowait: assert property (p_iowait)
    else $error("io cycle length out of range");
  a_release: assert property (p_release)
    else $error("data lines still driven in read sync");
  a_refresh: assert property (p_refresh)
    else $error("refresh strobe outside sync");
  a_fault: assert property (p_fault)
    else $error("memory write during supply fault");
  a_timer: assert property (p_timer)
    else $error("timer pin high with input low");
  a_wdog: assert property (p_wdog)
    else $error("watchdog reset without jumper");
  a_done: assert property (p_done)
    else $error("done longer than one cycle");
endmodule // cbbi_top_asserts

bind cbbi_top cbbi_top_asserts u_cbbi_top_asserts (.ref_clk_i, .rst_i,
  .supply_fault_i, .wdog_jumper_i, .timer_toggle_output_i, .cyc_done_o,
  .bus_data_o, .bus_data_oe_o, .bus_mem_rq_n_o, .bus_io_rq_n_o,
  .bus_rd_n_o, .bus_wr_n_o, .bus_mcsync_n_o, .bus_refresh_n_o,
  .bus_memex_o, .bus_ioexp_o, .timer_pin_o, .cpu_reset_o);

// *** testbench/tb.sv ***
// Self-checking bench of the backplane interface
`timescale 1ns/10ps
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] cyc_wdata = 8'h00;
  logic [15:0] cyc_addr = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cyc_req = 1'b0, cyc_io = 1'b0;
  logic cyc_write = 1'b0, cyc_fetch = 1'b0, fault = 1'b0;
  logic jumper = 1'b0, kick = 1'b0, toggle = 1'b0, dma = 1'b0;
  logic [7:0] reg_rdata, cyc_rdata, bus_out, card_d, bus_wire;
  logic [15:0] bus_addr;
  logic [1:0] sock_sel;
  logic cyc_done, cyc_int, oe, mem_n, io_n, rd_n, wr_n, sync_n, ref_n;
  logic memex, ioexp, tpin, cpu_rst, buf_dir;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  assign bus_wire = oe ? bus_out : card_d;

  cbbi_top #(.WDOG_CYCLES(100)) u_cbbi_top (.ref_clk_i, .rst_i,
    .clk_en_i(1'b1), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .cyc_req_i(cyc_req), .cyc_io_i(cyc_io), .cyc_write_i(cyc_write),
    .cyc_dma_i(dma), .cyc_fetch_i(cyc_fetch), .cyc_addr_i(cyc_addr),
    .cyc_wdata_i(cyc_wdata), .cyc_done_o(cyc_done),
    .cyc_rdata_o(cyc_rdata), .cyc_internal_o(cyc_int),
    .supply_fault_i(fault), .wdog_jumper_i(jumper), .wdog_kick_i(kick),
    .timer_toggle_output_i(toggle), .bus_addr_o(bus_addr),
    .bus_data_i(bus_wire), .bus_data_o(bus_out), .bus_data_oe_o(oe),
    .bus_mem_rq_n_o(mem_n), .bus_io_rq_n_o(io_n), .bus_rd_n_o(rd_n),
    .bus_wr_n_o(wr_n), .bus_mcsync_n_o(sync_n), .bus_refresh_n_o(ref_n),
    .bus_memex_o(memex), .bus_ioexp_o(ioexp), .timer_pin_o(tpin),
    .sock_sel_o(sock_sel), .buf_to_bus_o(buf_dir), .cpu_reset_o(cpu_rst));

  cbbi_card u_cbbi_card (.clk_i(ref_clk_i), .addr_i(bus_addr),
    .wire_i(bus_wire), .mem_n_i(mem_n), .io_n_i(io_n), .rd_n_i(rd_n),
    .sync_n_i(sync_n), .data_o(card_d));

  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk_i);
    reg_rd <= 1'b0;
    @(posedge ref_clk_i);
    chk(reg_rdata, exp);
  endtask

  // Request dropped in the done cycle so no second cycle starts
  task automatic cyc(input logic io, input logic w, input logic f,
      input logic [15:0] a, input int n, input logic [3:0] up,
      input logic [7:0] exp, input logic exp_ref);
    logic [15:0] ga;
    logic [7:0] gd, gw;
    logic wl = 1'b0, rf = 1'b0, early = 1'b0;
    @(posedge ref_clk_i);
    cyc_req <= 1'b1;
    cyc_io <= io;
    cyc_write <= w;
    cyc_fetch <= f;
    cyc_addr <= a;
    cyc_wdata <= exp;
    for (int k = 1; k <= 6 + n; k++) begin
      @(posedge ref_clk_i);
      // Pins show a state one edge after it is entered
      if (k == 3) ga = bus_addr;
      if (k == 3) gd = bus_out;
      if (k == 4) gw = bus_out;
      wl |= !wr_n;
      rf |= !ref_n;
      if (k < 6 + n) early |= cyc_done;
      if (k == 5 + n) cyc_req <= 1'b0;
    end
    chk(ga, a);
    chk(cyc_done && !early, 1'b1);
    if (!io) chk(gd, {4'h0, up});
    if (w) chk(gw, fault ? 8'h00 : exp);
    if (w) chk(wl, !fault);
    else chk(cyc_rdata, exp);
    chk(rf, exp_ref);
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    int k;
    logic bad;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 8'h20);
    rd(4'h1, 8'hf0);
    rd(4'h9, 8'h00);
    wr(4'h3, 8'h40);
    cyc(1'b0, 1'b0, 1'b1, 16'h1234, 0, 4'h4, 8'h44, 1'b1);
    dma <= 1'b1;
    cyc(1'b0, 1'b0, 1'b1, 16'h1234, 0, 4'h4, 8'h44, 1'b0);
    dma <= 1'b0;
    wr(4'h0, 8'h1b);
    cyc(1'b0, 1'b1, 1'b1, 16'h1234, 3, 4'h4, 8'h5a, 1'b0);
    cyc(1'b1, 1'b0, 1'b0, 16'habcd, 6, 4'h0, 8'hcd, 1'b0);
    fault <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    cyc(1'b0, 1'b1, 1'b0, 16'h2000, 3, 4'h4, 8'h3c, 1'b0);
    fault <= 1'b0;
    wr(4'h0, 8'h40);
    wr(4'h3, 8'h70);
    toggle <= 1'b1;
    cyc(1'b0, 1'b0, 1'b0, 16'h0100, 0, 4'h3, 8'h30, 1'b0);
    chk(tpin, 1'b1);
    wr(4'h3, 8'h00);
    wr(4'h5, 8'h21);
    cyc(1'b0, 1'b0, 1'b0, 16'h2000, 0, 4'h0, 8'h00, 1'b0);
    chk({buf_dir, sock_sel}, 3'b110);
    cyc(1'b0, 1'b1, 1'b0, 16'h0100, 0, 4'h0, 8'h11, 1'b0);
    chk({buf_dir, sock_sel}, 3'b001);
    wr(4'h6, 8'h04);
    @(posedge ref_clk_i);
    cyc_req <= 1'b1;
    cyc_io <= 1'b1;
    cyc_addr <= 16'h0105;
    @(posedge ref_clk_i);
    cyc_req <= 1'b0;
    @(posedge ref_clk_i);
    chk({cyc_int, io_n}, 2'b11);
    jumper <= 1'b1;
    k = 0;
    while (!cpu_rst && k < 200) begin
      @(posedge ref_clk_i);
      k++;
    end
    chk(k >= 100 && k <= 108, 1'b1);
    rd(4'h7, 8'h0e);
    bad = 1'b0;
    for (int i = 0; i < 240; i++) begin
      @(posedge ref_clk_i);
      kick <= (i % 40) < 3;
      if (i > 10) bad |= cpu_rst;
    end
    chk(bad, 1'b0);
    conclude();
  end
endmodule // tb
